// ==== bench/sbcl_bank_tracker_asserts.sv ====
// checker on the tracker ports, bound below
// assumes link and system clocks are unrelated
`timescale 1ns/100ps
module sbcl_bank_tracker_asserts #(
    parameter int RRD_CYC = 2
) (
    input wire logic       clkLink,
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       cke,
    input wire logic [3:0] cmd,
    input wire logic [2:0] bank,
    input wire logic       dataValid,
    input wire logic       dm,
    input wire logic       writeBeat,
    input wire logic       cmdIllegal,
    input wire logic [7:0] bankIdleSys,
    input wire logic       illegalSys
);
    // an accepted first command makes the second one illegal
    property p_pair(a, b);
        @(posedge clkLink) disable iff (rst)
        (cmd == a && cke && $past(cke) && !$past(rst)) ##1 (!cmdIllegal && cmd == b && cke) |=> cmdIllegal;
    endproperty
    property p_nopOk;
        @(posedge clkLink) disable iff (rst) cmd == sbcl_pkg::SBCL_NOP |=> !cmdIllegal;
    endproperty
    property p_ckeGate;
        @(posedge clkLink) disable iff (rst) !cke |=> !cmdIllegal;
    endproperty
    property p_dmMask;
        @(posedge clkLink) disable iff (rst) (!dataValid || dm) |=> !writeBeat;
    endproperty
    property p_rrd;
        @(posedge clkLink) disable iff (rst)
        (RRD_CYC > 1 && cmd == sbcl_pkg::SBCL_ACT && cke && $past(cke) && !$past(rst))
        ##1 (!cmdIllegal && cmd == sbcl_pkg::SBCL_ACT && cke) |=> cmdIllegal;
    endproperty
    property p_rdWr;
        @(posedge clkLink) disable iff (rst)
        (cmd == sbcl_pkg::SBCL_RD && cke && $past(cke) && !$past(rst))
        ##1 (!cmdIllegal && cmd == sbcl_pkg::SBCL_WR && cke && bank == $past(bank)) |=> cmdIllegal;
    endproperty
    property p_sysPulse;
        @(posedge clk_sys) disable iff (rst) illegalSys |=> !illegalSys;
    endproperty
    property p_idleRst;
        @(posedge clk_sys) disable iff (rst) $fell(rst) |-> ##[1:6] bankIdleSys == 8'hFF;
    endproperty
    a_nopOk:    assert property (p_nopOk) else $error("nop flagged illegal");
    a_ckeGate:  assert property (p_ckeGate) else $error("command checked with cke low");
    a_dmMask:   assert property (p_dmMask) else $error("masked beat written");
    a_rrd:      assert property (p_rrd) else $error("activate spacing not enforced");
    a_rdWr:     assert property (p_rdWr) else $error("write accepted during read");
    a_mrwHold:  assert property (p_pair(sbcl_pkg::SBCL_MRW, sbcl_pkg::SBCL_ACT))
        else $error("command in mrw");
    a_bstTwice: assert property (p_pair(sbcl_pkg::SBCL_BST, sbcl_pkg::SBCL_BST))
        else $error("bst w/o burst");
    a_sysPulse: assert property (p_sysPulse) else $error("illegal pulse too long");
    a_idleRst:  assert property (p_idleRst) else $error("banks not idle after reset");
    c_illegal:  cover property (@(posedge clkLink) cmdIllegal);
    c_beat:     cover property (@(posedge clkLink) writeBeat);
    c_sys:      cover property (@(posedge clk_sys) illegalSys);
endmodule
bind sbcl_bank_tracker sbcl_bank_tracker_asserts #(.RRD_CYC(RRD_CYC)) sbcl_bank_tracker_asserts_inst (
    .clkLink(clkLink), .clk_sys(clk_sys), .rst(rst), .cke(cke), .cmd(cmd), .bank(bank),
    .dataValid(dataValid), .dm(dm), .writeBeat(writeBeat), .cmdIllegal(cmdIllegal),
    .bankIdleSys(bankIdleSys), .illegalSys(illegalSys));

// ==== bench/sbcl_ctrl_model.sv ====
// controller model issuing commands and write beats
// assumes step is called at a falling link edge
`timescale 1ns/100ps
module sbcl_ctrl_model (
    input  wire logic clkLink,
    input  wire logic writeBeat,
    input  wire logic cmdIllegal,
    output logic [3:0] cmd,
    output logic [2:0] bank,
    output logic       autoPre,
    output logic       dataValid,
    output logic       dm
);
    initial begin
        cmd = sbcl_pkg::SBCL_NOP;
        bank = 3'h0;
        autoPre = 1'b0;
        dataValid = 1'b0;
        dm = 1'b0;
    end
    // one command per cycle, held for the whole cycle; unused lanes toggle
    task automatic step(input logic [3:0] c, input logic [2:0] b, input logic v, input logic m,
                        output logic ill, output logic wb);
        cmd = c;
        bank = (c == sbcl_pkg::SBCL_NOP) ? ~bank : b;
        dataValid = v;
        dm = v ? m : ~dm;
        @(negedge clkLink);
        ill = cmdIllegal;
        wb = writeBeat;
    endtask
    // auto precharge qualifier, held for every later read or write until set again
    task automatic setAutoPre(input logic a);
        autoPre = a;
    endtask
endmodule

// ==== bench/tb_sdram_bank_command_legality.sv ====
// self-checking bench for the bank command tracker
// assumes the checker is bound and the model plays the controller
`timescale 1ns/100ps
module tb_sdram_bank_command_legality;
    logic       clkLink = 1'b0;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       cke = 1'b0;
    logic [3:0] cmd;
    logic [2:0] bank, b;
    logic       autoPre, dataValid, dm, writeBeat, cmdIllegal, illegalSys, ill, wb;
    logic [7:0] bankIdleSys;
    int         n_fail = 0;
    int         num_checks = 0;
    int         nSysPulse = 0;
    int         g;
    int         p0;
    localparam int RRD = 2;
    always @(negedge clk_sys) begin
        if (illegalSys === 1'b1) begin
            nSysPulse++;
        end
    end
    always #16 clkLink = ~clkLink;
    always #25 clk_sys = ~clk_sys;
    sbcl_bank_tracker #(.RRD_CYC(RRD)) sbcl_bank_tracker_inst (.clkLink(clkLink), .clk_sys(clk_sys), .rst(rst),
        .cke(cke), .cmd(cmd), .bank(bank), .autoPre(autoPre), .dataValid(dataValid), .dm(dm),
        .writeBeat(writeBeat), .cmdIllegal(cmdIllegal), .bankIdleSys(bankIdleSys), .illegalSys(illegalSys));
    sbcl_ctrl_model sbcl_ctrl_model_inst (.clkLink(clkLink), .writeBeat(writeBeat), .cmdIllegal(cmdIllegal),
        .cmd(cmd), .bank(bank), .autoPre(autoPre), .dataValid(dataValid), .dm(dm));
    function automatic logic [7:0] expBeat(input logic v, input logic m);
        return {7'h00, v & ~m};
    endfunction
    // a second activate gap-plus-one cycles after the first breaks the spacing when gap-plus-one is below RRD
    function automatic logic actTooSoon(input int gap);
        return (gap + 1) < RRD;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmdChk(input logic [3:0] c, input logic [2:0] bk, input logic expIll);
        sbcl_ctrl_model_inst.step(c, bk, 1'b0, 1'b0, ill, wb);
        check("cmdIllegal", {7'h00, ill}, {7'h00, expIll});
    endtask
    task automatic idle(input int n);
        repeat (n) sbcl_ctrl_model_inst.step(sbcl_pkg::SBCL_NOP, 3'h0, 1'b0, 1'b0, ill, wb);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #50000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'hA9AE));
        b = 3'($urandom_range(7));
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clkLink);
        cke = 1'b1;
        idle(8);
        cmdChk(sbcl_pkg::SBCL_ACT, b, 1'b0);
        cmdChk(sbcl_pkg::SBCL_RD, b, 1'b1);
        cmdChk(sbcl_pkg::SBCL_MRR, b, 1'b0);
        cmdChk(sbcl_pkg::SBCL_RD, b, 1'b1);
        idle(4);
        cmdChk(sbcl_pkg::SBCL_RD, b, 1'b0);
        cmdChk(sbcl_pkg::SBCL_WR, b, 1'b1);
        cmdChk(sbcl_pkg::SBCL_BST, b, 1'b0);
        cmdChk(sbcl_pkg::SBCL_BST, b, 1'b1);
        for (int i = 0; i < 4; i++) begin
            cmdChk(sbcl_pkg::SBCL_WR, b, 1'b0);
            sbcl_ctrl_model_inst.step(sbcl_pkg::SBCL_NOP, b, i[1], i[0], ill, wb);
            check("writeBeat", {7'h00, wb}, expBeat(i[1], i[0]));
        end
        idle(3);
        cmdChk(sbcl_pkg::SBCL_WR, b, 1'b0);
        cmdChk(sbcl_pkg::SBCL_RD, b, 1'b1);
        cmdChk(sbcl_pkg::SBCL_BST, b, 1'b0);
        cmdChk(sbcl_pkg::SBCL_PRE, b, 1'b0);
        cmdChk(sbcl_pkg::SBCL_MRR, b, 1'b0);
        idle(5);
        cmdChk(sbcl_pkg::SBCL_REF, b, 1'b0);
        $display("test access done");
        cmdChk(sbcl_pkg::SBCL_ACT, b, 1'b0);
        cmdChk(sbcl_pkg::SBCL_ACT, b + 3'h1, 1'b1);
        idle(8);
        check("bankIdleSys", bankIdleSys, ~(8'h01 << b));
        cmdChk(sbcl_pkg::SBCL_REF, b, 1'b1);
        cmdChk(sbcl_pkg::SBCL_MRW, b, 1'b1);
        sbcl_ctrl_model_inst.setAutoPre(1'b1);
        cmdChk(sbcl_pkg::SBCL_RD, b, 1'b0);
        sbcl_ctrl_model_inst.setAutoPre(1'b0);
        cmdChk(sbcl_pkg::SBCL_ACT, b + 3'h1, 1'b0);
        cmdChk(sbcl_pkg::SBCL_PREA, b, 1'b0);
        idle(5);
        cmdChk(sbcl_pkg::SBCL_MRW, b, 1'b0);
        cmdChk(sbcl_pkg::SBCL_ACT, b, 1'b1);
        idle(6);
        cmdChk(sbcl_pkg::SBCL_ACT, b, 1'b0);
        cmdChk(sbcl_pkg::SBCL_PREA, b, 1'b0);
        idle(10);
        check("bankIdleSys", bankIdleSys, 8'hFF);
        $display("test all-bank done");
        cke = 1'b0;
        idle(1);
        cmdChk(sbcl_pkg::SBCL_RD, b, 1'b0);
        cke = 1'b1;
        idle(2);
        p0 = nSysPulse;
        cmdChk(sbcl_pkg::SBCL_RD, b, 1'b1);
        idle(8);
        check("illegalSys", 8'(nSysPulse - p0), 8'h01);
        $display("test cke done");
        cmdChk(sbcl_pkg::SBCL_ACT, b, 1'b0);
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        check("cmdIllegal", {7'h00, cmdIllegal}, 8'h00);
        check("bankIdleSys", bankIdleSys, 8'h00);
        rst = 1'b0;
        @(negedge clkLink);
        idle(8);
        check("bankIdleSys", bankIdleSys, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            g = $urandom_range(3);
            cmdChk(sbcl_pkg::SBCL_ACT, b, 1'b0);
            idle(g);
            cmdChk(sbcl_pkg::SBCL_ACT, b + 3'h1, actTooSoon(g));
            cmdChk(sbcl_pkg::SBCL_PREA, b, 1'b0);
            idle(4);
        end
        $display("test reset done");
        report_and_stop();
    end
endmodule

// ==== rtl/sbcl_bank_tracker.sv ====
// per-bank state tracker and command legality checker
// assumes cmd, bank, ap and dm come from logic on the link clock
`timescale 1ns/100ps
module sbcl_bank_tracker #(
    parameter int RRD_CYC = 2
) (
    input  wire logic                      clkLink,
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      cke,
    input  wire logic [3:0]                cmd,
    input  wire logic [2:0]                bank,
    input  wire logic                      autoPre,
    input  wire logic                      dataValid,
    input  wire logic                      dm,
    output logic                           writeBeat,
    output logic                           cmdIllegal,
    output logic [7:0]                     bankIdleSys,
    output logic                           illegalSys
);
    sbcl_pkg::sbcl_state_e st [8];
    sbcl_pkg::sbcl_state_e next_st [8];
    logic [3:0]  tmr [8];
    logic [3:0]  next_tmr [8];
    logic [7:0]  apFlag, next_apFlag;
    sbcl_pkg::sbcl_state_e prior [8];
    sbcl_pkg::sbcl_state_e next_prior [8];
    logic        ckePrev;
    logic [2:0]  lastBank, next_lastBank;
    logic [3:0]  rrdCnt, next_rrdCnt;
    logic        next_illegal, next_writeBeat;
    logic [7:0]  idleVec;
    logic        illegalTgl, next_illegalTgl;
    logic [7:0]  idleLink;
    logic [7:0]  idleS1, idleS2;
    logic [2:0]  tglS;

    function automatic logic precharge_ok(sbcl_pkg::sbcl_state_e s);
        return s == sbcl_pkg::SBCL_IDLE || s == sbcl_pkg::SBCL_ACTIVE || s == sbcl_pkg::SBCL_ROWACT
            || s == sbcl_pkg::SBCL_READING || s == sbcl_pkg::SBCL_WRITING || s == sbcl_pkg::SBCL_PRECHG;
    endfunction

    always_comb begin
        logic allIdle;
        logic anyMr;
        logic bad;
        sbcl_pkg::sbcl_cmd_e c;
        allIdle = 1'b1;
        anyMr = 1'b0;
        bad = 1'b0;
        c = sbcl_pkg::sbcl_cmd_e'(cmd);
        for (int i = 0; i < 8; i++) begin
            idleVec[i] = st[i] == sbcl_pkg::SBCL_IDLE;
            allIdle = allIdle & idleVec[i];
            anyMr = anyMr | (st[i] == sbcl_pkg::SBCL_MRRD) | (st[i] == sbcl_pkg::SBCL_MRWR);
            next_st[i] = st[i];
            next_prior[i] = prior[i];
            next_apFlag[i] = apFlag[i];
            next_tmr[i] = (tmr[i] != 4'h0) ? tmr[i] - 4'h1 : 4'h0;
        end
        next_lastBank = lastBank;
        next_rrdCnt = (rrdCnt != 4'h0) ? rrdCnt - 4'h1 : 4'h0;
        next_writeBeat = dataValid & ~dm & (st[lastBank] == sbcl_pkg::SBCL_WRITING);
        // timed transitions
        for (int i = 0; i < 8; i++) begin
            if (tmr[i] == 4'h1) begin
                case (st[i])
                    sbcl_pkg::SBCL_ROWACT:  next_st[i] = sbcl_pkg::SBCL_ACTIVE;
                    sbcl_pkg::SBCL_PRECHG:  next_st[i] = sbcl_pkg::SBCL_IDLE;
                    sbcl_pkg::SBCL_MRWR:    next_st[i] = sbcl_pkg::SBCL_IDLE;
                    sbcl_pkg::SBCL_MRRD:    next_st[i] = prior[i];
                    sbcl_pkg::SBCL_READING,
                    sbcl_pkg::SBCL_WRITING: begin
                        next_st[i] = apFlag[i] ? sbcl_pkg::SBCL_PRECHG : sbcl_pkg::SBCL_ACTIVE;
                        next_tmr[i] = apFlag[i] ? sbcl_pkg::T_RP : 4'h0;
                        next_apFlag[i] = 1'b0;
                    end
                    default: next_st[i] = st[i];
                endcase
            end
        end
        // command decode; ignored unless clock enable held high two cycles
        if (cke && ckePrev && c != sbcl_pkg::SBCL_NOP) begin
            if (anyMr)
                bad = 1'b1;
            else begin
                case (c)
                    sbcl_pkg::SBCL_ACT: begin
                        if (st[bank] != sbcl_pkg::SBCL_IDLE || rrdCnt != 4'h0)
                            bad = 1'b1;
                        else begin
                            next_st[bank] = sbcl_pkg::SBCL_ROWACT;
                            next_tmr[bank] = sbcl_pkg::T_RCD;
                            // an activate RRD_CYC cycles later is already legal
                            next_rrdCnt = 4'(RRD_CYC - 1);
                        end
                    end
                    sbcl_pkg::SBCL_RD, sbcl_pkg::SBCL_WR: begin
                        if (!(st[bank] == sbcl_pkg::SBCL_ACTIVE
                              || (c == sbcl_pkg::SBCL_RD && st[bank] == sbcl_pkg::SBCL_READING)
                              || (c == sbcl_pkg::SBCL_WR && st[bank] == sbcl_pkg::SBCL_WRITING)))
                            bad = 1'b1;
                        else begin
                            next_st[bank] = (c == sbcl_pkg::SBCL_RD) ? sbcl_pkg::SBCL_READING
                                                                    : sbcl_pkg::SBCL_WRITING;
                            next_tmr[bank] = sbcl_pkg::T_BURST;
                            next_apFlag[bank] = autoPre;
                            next_lastBank = bank;
                        end
                    end
                    sbcl_pkg::SBCL_PRE: begin
                        if (!precharge_ok(st[bank]))
                            bad = 1'b1;
                        else begin
                            next_st[bank] = sbcl_pkg::SBCL_PRECHG;
                            next_tmr[bank] = sbcl_pkg::T_RP;
                        end
                    end
                    sbcl_pkg::SBCL_PREA: begin
                        for (int i = 0; i < 8; i++) begin
                            if (!precharge_ok(st[i]))
                                bad = 1'b1;
                        end
                        if (!bad) begin
                            for (int i = 0; i < 8; i++) begin
                                next_st[i] = sbcl_pkg::SBCL_PRECHG;
                                next_tmr[i] = sbcl_pkg::T_RP;
                            end
                        end
                    end
                    sbcl_pkg::SBCL_BST: begin
                        if (st[lastBank] != sbcl_pkg::SBCL_READING && st[lastBank] != sbcl_pkg::SBCL_WRITING)
                            bad = 1'b1;
                        else begin
                            next_st[lastBank] = sbcl_pkg::SBCL_ACTIVE;
                            next_tmr[lastBank] = 4'h0;
                            next_apFlag[lastBank] = 1'b0;
                        end
                    end
                    sbcl_pkg::SBCL_MRR: begin
                        if (st[bank] == sbcl_pkg::SBCL_READING || st[bank] == sbcl_pkg::SBCL_WRITING)
                            bad = 1'b1;
                        else begin
                            next_prior[bank] = (st[bank] == sbcl_pkg::SBCL_ROWACT) ? sbcl_pkg::SBCL_ACTIVE
                                             : (st[bank] == sbcl_pkg::SBCL_PRECHG) ? sbcl_pkg::SBCL_IDLE
                                             : st[bank];
                            next_st[bank] = sbcl_pkg::SBCL_MRRD;
                            next_tmr[bank] = sbcl_pkg::T_MRR;
                        end
                    end
                    sbcl_pkg::SBCL_MRW, sbcl_pkg::SBCL_REF: begin
                        if (!allIdle && !(c == sbcl_pkg::SBCL_MRW && st[0] == sbcl_pkg::SBCL_RESET))
                            bad = 1'b1;
                        else if (c == sbcl_pkg::SBCL_MRW) begin
                            for (int i = 0; i < 8; i++) begin
                                next_st[i] = sbcl_pkg::SBCL_MRWR;
                                next_tmr[i] = sbcl_pkg::T_MRW;
                            end
                        end
                    end
                    default: bad = 1'b1;
                endcase
            end
        end
        next_illegal = bad;
        next_illegalTgl = illegalTgl ^ bad;
    end

    always_ff @(posedge clkLink or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                st[i] <= sbcl_pkg::SBCL_IDLE;
                prior[i] <= sbcl_pkg::SBCL_IDLE;
                tmr[i] <= 4'h0;
            end
            apFlag <= 8'h00;
            ckePrev <= 1'b0;
            lastBank <= 3'h0;
            rrdCnt <= 4'h0;
            cmdIllegal <= 1'b0;
            writeBeat <= 1'b0;
            illegalTgl <= 1'b0;
            idleLink <= 8'h00;
        end else begin
            st <= next_st;
            prior <= next_prior;
            tmr <= next_tmr;
            apFlag <= next_apFlag;
            ckePrev <= cke;
            lastBank <= next_lastBank;
            rrdCnt <= next_rrdCnt;
            cmdIllegal <= next_illegal;
            writeBeat <= next_writeBeat;
            illegalTgl <= next_illegalTgl;
            idleLink <= idleVec;
        end
    end

    // crossing to system clock: registered idle levels by three flops, illegal event by toggle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            idleS1 <= 8'h00;
            idleS2 <= 8'h00;
            tglS <= 3'h0;
            bankIdleSys <= 8'h00;
            illegalSys <= 1'b0;
        end else begin
            idleS1 <= idleLink;
            idleS2 <= idleS1;
            tglS <= {tglS[1:0], illegalTgl};
            bankIdleSys <= idleS2;
            // an event right behind a pulse merges into it
            illegalSys <= (tglS[2] ^ tglS[1]) & ~illegalSys;
        end
    end
endmodule

// ==== rtl/sbcl_pkg.sv ====
// package for the per-bank command legality tracker
// assumes commands arrive already decoded on the link clock
package sbcl_pkg;
    localparam int NUM_BANKS     = 8;
    localparam int BANK_W        = 3;
    localparam int CNT_W         = 4;
    // timing figures in link clock cycles
    localparam logic [3:0] T_RCD = 4'h3;
    localparam logic [3:0] T_RP  = 4'h3;
    localparam logic [3:0] T_MRR = 4'h2;
    localparam logic [3:0] T_MRW = 4'h5;
    localparam logic [3:0] T_BURST = 4'h2;
    // command encodings
    typedef enum logic [3:0] {
        SBCL_NOP     = 4'h0,
        SBCL_ACT     = 4'h1,
        SBCL_RD      = 4'h2,
        SBCL_WR      = 4'h3,
        SBCL_PRE     = 4'h4,
        SBCL_PREA    = 4'h5,
        SBCL_BST     = 4'h6,
        SBCL_MRR     = 4'h7,
        SBCL_MRW     = 4'h8,
        SBCL_REF     = 4'h9
    } sbcl_cmd_e;
    // bank states
    typedef enum logic [3:0] {
        SBCL_IDLE    = 4'h0,
        SBCL_ROWACT  = 4'h1,
        SBCL_ACTIVE  = 4'h2,
        SBCL_READING = 4'h3,
        SBCL_WRITING = 4'h4,
        SBCL_PRECHG  = 4'h5,
        SBCL_MRRD    = 4'h6,
        SBCL_MRWR    = 4'h7,
        SBCL_RESET   = 4'h8
    } sbcl_state_e;
endpackage
